// *** src/dsc_cal_if.sv ***
// Carrier between the control top and the calibration multiplier
interface dsc_cal_if;
  logic [dsc_pkg::CODE_W-1:0] data;
  logic [dsc_pkg::CODE_W-1:0] gain;
  logic [dsc_pkg::CODE_W-1:0] offset;
  logic                       load;
  logic [dsc_pkg::CODE_W-1:0] code;
  logic                       code_valid;

  modport calc (input data, gain, offset, load, output code, code_valid);
  modport user (output data, gain, offset, load, input code, code_valid);
endinterface : dsc_cal_if

// *** src/dsc_calib.sv ***
// Gain and offset calibration of the written output code
module dsc_calib (
  // Clock, reset and enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Calibration port
  dsc_cal_if.calc   cal
);

  localparam int unsigned PW = 2 * dsc_pkg::CODE_W + 2;

  logic [PW-1:0]                prod;
  logic signed [PW-1:0]         sum;
  logic [dsc_pkg::CODE_W-1:0]   code_d;

  // Gain is 0.5 + gain/2^N; low bits dropped, never rounded
  always_comb begin
    prod = PW'(cal.data) * PW'({1'b0, cal.gain} + 17'h08000);
    sum  = $signed(PW'(prod >> dsc_pkg::CODE_W))
         + PW'($signed(cal.offset));
    // Saturate rather than wrap across the scale ends
    if (sum < 0) begin
      code_d = '0;
    end else if (sum > $signed(PW'({dsc_pkg::CODE_W{1'b1}}))) begin
      code_d = '1;
    end else begin
      code_d = sum[dsc_pkg::CODE_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cal.code       <= '0;
      cal.code_valid <= 1'b0;
    end else if (ce) begin
      cal.code_valid <= cal.load;
      if (cal.load) begin
        cal.code <= code_d;
      end
    end
  end

endmodule // dsc_calib

// *** src/dsc_pkg.sv ***
// Constants and types shared by the DAC slew and clear control block
package dsc_pkg;

  // Code path width (high resolution variant)
  localparam int unsigned CODE_W        = 16;
  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned LOWRES_DROP   = 2;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLEW_BASE_NS  = 1000;
  localparam int unsigned SLEW_BASE_CYC = (SLEW_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned DIV_W         = 24;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DATA     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CFG      = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_GAIN     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_OFFSET   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CLR_CODE = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_ALARM    = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_APPLIED  = 4'h7;

  // Configuration register fields
  localparam int unsigned CFG_RANGE     = 0;
  localparam int unsigned CFG_CLEAR_RANGE_SELECT = 1;
  localparam int unsigned CFG_CLR_REQ   = 2;
  localparam int unsigned CFG_SLEW_EN   = 3;
  localparam int unsigned CFG_STEP_LSB  = 4;
  localparam int unsigned CFG_RATE_LSB  = 7;
  localparam int unsigned CFG_PROFILE   = 10;
  localparam int unsigned CFG_BITS      = 11;

  // Alarm response field and status bits
  localparam int unsigned ALM_CLEAR     = 0;
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_CLEAR      = 1;
  localparam int unsigned ST_RANGE      = 2;

  // Reset values
  localparam logic [CODE_W-1:0]   RST_DATA     = 16'h0000;
  localparam logic [CODE_W-1:0]   RST_GAIN     = 16'h8000;
  localparam logic [CODE_W-1:0]   RST_OFFSET   = 16'h0000;
  localparam logic [CODE_W-1:0]   RST_CLR_CODE = 16'h0000;
  localparam logic [CFG_BITS-1:0] RST_CFG      = 11'h000;
  localparam logic                RST_ALARM    = 1'b0;

  // Profile encoding
  localparam logic PROFILE_LINEAR = 1'b0;

  // Slew engine states
  typedef enum logic [1:0] {
    SLW_IDLE = 2'b01,
    SLW_STEP = 2'b10
  } dsc_slew_state_t;

endpackage : dsc_pkg

// *** src/dsc_top.sv ***
// DAC slew and clear control: register port, calibration, slew engine, clear
module dsc_top #(
  parameter bit          LOW_RES  = 1'b0,
  parameter int unsigned BASE_CYC = dsc_pkg::SLEW_BASE_CYC
) (
  // Clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // Register port
  input  wire logic [dsc_pkg::ADDR_W-1:0]    addr,
  input  wire logic [dsc_pkg::CODE_W-1:0]    wr_data,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [dsc_pkg::CODE_W-1:0]    rd_data,
  // Clear sources
  input  wire logic                          alarm_in,
  input  wire logic                          break_mode_interface,
  input  wire logic                          sdi_in,
  // Converter side
  output logic      [dsc_pkg::CODE_W-1:0]    dac_code,
  output logic                               range_narrow,
  output logic                               clear_state,
  output logic                               slew_in_progress
);

  localparam int unsigned W = dsc_pkg::CODE_W;
  localparam logic [W-1:0] RES_MASK = LOW_RES ? {{(W-dsc_pkg::LOWRES_DROP){1'b1}},
                                                 {dsc_pkg::LOWRES_DROP{1'b0}}} : {W{1'b1}};

  // Registers
  logic [W-1:0]                  data_q;
  logic [W-1:0]                  gain_q;
  logic [W-1:0]                  offset_q;
  logic [W-1:0]                  clr_code_q;
  logic [dsc_pkg::CFG_BITS-1:0]  cfg_q;
  logic                          alarm_cfg_q;
  logic [W-1:0]                  rd_data_q;

  // Code path
  logic                          load_q;
  logic [W-1:0]                  cal_code_q;
  logic [W-1:0]                  target;
  logic [W-1:0]                  applied_q;
  logic [W-1:0]                  span_q;
  logic [W-1:0]                  prev_target_q;
  logic [dsc_pkg::DIV_W-1:0]     div_q;
  logic                          tick;
  dsc_pkg::dsc_slew_state_t      st_q;

  // Config fields
  logic                          slew_enable;
  logic [2:0]                    slew_step_size;
  logic [2:0]                    slew_update_rate;
  logic                          slew_profile_select;
  logic                          clear_request_bit;
  logic                          clear_range_select;
  logic                          range_sel;
  logic                          clear_active;

  dsc_cal_if cal ();

  assign slew_enable         = cfg_q[dsc_pkg::CFG_SLEW_EN];
  assign slew_step_size      = cfg_q[dsc_pkg::CFG_STEP_LSB +: 3];
  assign slew_update_rate    = cfg_q[dsc_pkg::CFG_RATE_LSB +: 3];
  assign slew_profile_select = cfg_q[dsc_pkg::CFG_PROFILE];
  assign clear_request_bit   = cfg_q[dsc_pkg::CFG_CLR_REQ];
  assign clear_range_select  = cfg_q[dsc_pkg::CFG_CLEAR_RANGE_SELECT];
  assign range_sel           = cfg_q[dsc_pkg::CFG_RANGE];

  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q      <= dsc_pkg::RST_DATA;
      gain_q      <= dsc_pkg::RST_GAIN;
      offset_q    <= dsc_pkg::RST_OFFSET;
      clr_code_q  <= dsc_pkg::RST_CLR_CODE;
      cfg_q       <= dsc_pkg::RST_CFG;
      alarm_cfg_q <= dsc_pkg::RST_ALARM;
    end else if (ce && wr_en) begin
      unique case (addr)
        dsc_pkg::OFS_DATA:     data_q      <= wr_data & RES_MASK;
        dsc_pkg::OFS_CFG:      cfg_q       <= wr_data[dsc_pkg::CFG_BITS-1:0];
        dsc_pkg::OFS_GAIN:     gain_q      <= wr_data & RES_MASK;
        dsc_pkg::OFS_OFFSET:   offset_q    <= wr_data & RES_MASK;
        dsc_pkg::OFS_CLR_CODE: clr_code_q  <= wr_data & RES_MASK;
        dsc_pkg::OFS_ALARM:    alarm_cfg_q <= wr_data[dsc_pkg::ALM_CLEAR];
        default: ;
      endcase
    end
  end

  // Read data stands for one cycle only; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= '0;
      if (rd_en) begin
        unique case (addr)
          dsc_pkg::OFS_DATA:     rd_data_q <= data_q;
          dsc_pkg::OFS_CFG:      rd_data_q <= W'(cfg_q);
          dsc_pkg::OFS_GAIN:     rd_data_q <= gain_q;
          dsc_pkg::OFS_OFFSET:   rd_data_q <= offset_q;
          dsc_pkg::OFS_CLR_CODE: rd_data_q <= clr_code_q;
          dsc_pkg::OFS_ALARM:    rd_data_q <= W'(alarm_cfg_q);
          dsc_pkg::OFS_STATUS:   rd_data_q <= W'({range_narrow, clear_state, slew_in_progress});
          dsc_pkg::OFS_APPLIED:  rd_data_q <= applied_q;
          default:               rd_data_q <= '0;
        endcase
      end
    end
  end

  assign rd_data = rd_data_q;

  // Any data, gain or offset write re-runs calibration; gain and offset
  // alone would otherwise wait for a data write, which hides trim edits
  always_ff @(posedge clk) begin
    if (rst) begin
      load_q <= 1'b1;
    end else if (ce) begin
      load_q <= wr_en && (addr == dsc_pkg::OFS_DATA || addr == dsc_pkg::OFS_GAIN
                          || addr == dsc_pkg::OFS_OFFSET);
    end
  end

  assign cal.data   = data_q;
  assign cal.gain   = gain_q;
  assign cal.offset = offset_q;
  assign cal.load   = load_q;

  dsc_calib u_calib (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .cal (cal.user)
  );

  // Second resync stage before the code reaches the slew engine
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_code_q <= '0;
    end else if (ce && cal.code_valid) begin
      cal_code_q <= cal.code & RES_MASK;
    end
  end

  // Clear sources
  assign clear_active = clear_request_bit
                      | (alarm_in & alarm_cfg_q)
                      | (break_mode_interface & sdi_in);

  // Clear code replaces the calibrated code; data register left alone
  assign target = clear_active ? (clr_code_q & RES_MASK) : cal_code_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      clear_state  <= 1'b0;
      range_narrow <= 1'b0;
    end else if (ce) begin
      clear_state  <= clear_active;
      range_narrow <= clear_active ? clear_range_select : range_sel;
    end
  end

  // Update-rate divider: depends on rate field only, never on range
  logic [dsc_pkg::DIV_W-1:0] div_top;
  assign div_top = dsc_pkg::DIV_W'(BASE_CYC << slew_update_rate) - 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else if (ce) begin
      if (st_q == dsc_pkg::SLW_IDLE || div_q >= div_top) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  assign tick = (st_q == dsc_pkg::SLW_STEP) && (div_q >= div_top);

  // Step size with profile shaping
  logic [W-1:0] remain;
  logic [W-1:0] done_dist;
  logic [W-1:0] base_step;
  logic [W-1:0] step_amt;
  logic [W-1:0] step_use;
  logic         going_up;

  always_comb begin
    going_up  = target > applied_q;
    remain    = going_up ? (target - applied_q) : (applied_q - target);
    done_dist = (span_q > remain) ? (span_q - remain) : '0;
    base_step = W'(1) << slew_step_size;
    step_amt  = base_step;
    if (slew_profile_select != dsc_pkg::PROFILE_LINEAR) begin
      // Ease in and out: quarter step in outer eighths, half in outer quarters
      if (done_dist < (span_q >> 3) || remain < (span_q >> 3)) begin
        step_amt = base_step >> 2;
      end else if (done_dist < (span_q >> 2) || remain < (span_q >> 2)) begin
        step_amt = base_step >> 1;
      end
      if (step_amt == '0) begin
        step_amt = W'(1);
      end
    end
    // Never overshoot, so the target is reached exactly
    step_use = (step_amt > remain) ? remain : step_amt;
  end

  // Slew state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= dsc_pkg::SLW_IDLE;
    end else if (ce) begin
      unique case (st_q)
        dsc_pkg::SLW_IDLE: begin
          if (slew_enable && target != applied_q) begin
            st_q <= dsc_pkg::SLW_STEP;
          end
        end
        dsc_pkg::SLW_STEP: begin
          if (!slew_enable) begin
            st_q <= dsc_pkg::SLW_IDLE;
          end else if (tick && step_use == remain) begin
            st_q <= dsc_pkg::SLW_IDLE;
          end
        end
      endcase
    end
  end

  // Applied code
  always_ff @(posedge clk) begin
    if (rst) begin
      applied_q <= '0;
    end else if (ce) begin
      if (!slew_enable) begin
        applied_q <= target;
      end else if (tick) begin
        applied_q <= going_up ? applied_q + step_use
                              : applied_q - step_use;
      end
    end
  end

  // Span of the current transition, relatched when the target moves
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_target_q <= '0;
      span_q        <= '0;
    end else if (ce) begin
      prev_target_q <= target;
      if (target != prev_target_q || st_q == dsc_pkg::SLW_IDLE) begin
        span_q <= remain;
      end
    end
  end

  assign dac_code         = applied_q;
  assign slew_in_progress = (st_q == dsc_pkg::SLW_STEP);

endmodule // dsc_top

// *** tb/dsc_host.sv ***
// Host model driving the register port
module dsc_host (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic      [3:0]  addr,
  output logic      [15:0] wr_data,
  output logic             wr_en,
  output logic             rd_en,
  input  wire logic [15:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_en = 1'h0;
    rd_en = 1'h0;
  end
  // Gain and offset are only rewritten with slew off
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    @(posedge clk);
    d = rd_data;
  endtask
endmodule // dsc_host

// *** tb/dsc_top_monitor.sv ***
// Port checker for the slew and clear control block
module dsc_top_monitor #(
  parameter bit          LOW_RES  = 1'b0,
  parameter int unsigned BASE_CYC = 1
) (
  // Clock, reset, enable
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  // Clear sources
  input wire logic        alarm_in,
  input wire logic        break_mode_interface,
  input wire logic        sdi_in,
  // Converter side
  input wire logic [15:0] dac_code,
  input wire logic        range_narrow,
  input wire logic        clear_state,
  input wire logic        slew_in_progress
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [10:0] cfg_q;
  logic [15:0] code_q;
  logic [15:0] prev_q;
  logic        clr_q;
  logic        seen_q;
  logic [2:0]  quiet_q;
  int          gap_q;
  logic        chg;
  logic [15:0] delta;
  assign chg   = dac_code != prev_q;
  assign delta = dac_code > prev_q ? dac_code - prev_q : prev_q - dac_code;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= dsc_pkg::RST_CFG;
    end else if (ce && wr_en && addr == dsc_pkg::OFS_CFG) begin
      cfg_q <= wr_data[10:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      code_q <= dsc_pkg::RST_CLR_CODE;
    end else if (ce && wr_en && addr == dsc_pkg::OFS_CLR_CODE) begin
      code_q <= wr_data;
    end
  end
  always_ff @(posedge clk) begin
    prev_q <= dac_code;
    clr_q  <= clear_state;
  end
  // A new target may restart the tick, so spacing is judged only well after one
  always_ff @(posedge clk) begin
    if (rst || wr_en || clear_state != clr_q) begin
      quiet_q <= 3'h7;
    end else if (quiet_q != 3'h0) begin
      quiet_q <= quiet_q - 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    gap_q  <= (rst || chg) ? 0 : gap_q + 1;
    seen_q <= (rst || quiet_q != 3'h0 || !slew_in_progress) ? 1'b0 : (seen_q || chg);
  end
  AST_RST_QUIET: assert property ($fell(rst) |-> dac_code == 16'h0000 && !clear_state && !range_narrow && !slew_in_progress)
    else $error("outputs not idle after reset");
  AST_SLEW_OFF_IDLE: assert property (!cfg_q[3] && !$past(cfg_q[3]) |-> !slew_in_progress)
    else $error("stepping while slew control is off");
  AST_STEP_MAX: assert property (cfg_q[3] && $past(cfg_q[3]) |-> delta <= (16'h0001 << $past(cfg_q[6:4])))
    else $error("code moved by more than one step");
  AST_SLEW_SPACING: assert property (seen_q && chg && slew_in_progress |-> gap_q == (BASE_CYC << cfg_q[9:7]) - 1)
    else $error("update spacing does not match rate");
  AST_CLEAR_BIT: assert property (wr_en && addr == dsc_pkg::OFS_CFG && wr_data[2] |-> ##2 clear_state)
    else $error("clear request bit did not enter clear");
  AST_SDI_CLEAR: assert property (break_mode_interface && sdi_in |=> clear_state)
    else $error("pin clear in break mode ignored");
  AST_RANGE_SEL: assert property ($stable(cfg_q) && $stable(clear_state)
    |-> range_narrow == (clear_state ? cfg_q[1] : cfg_q[0]))
    else $error("wrong range source");
  AST_CLEAR_CODE: assert property ($rose(clear_state) && !cfg_q[3] |-> ##[0:4] dac_code == code_q)
    else $error("clear code not applied");
  cover property (seen_q && chg);
  cover property ($rose(clear_state) && cfg_q[3]);
  cover property ($fell(cfg_q[3]) && slew_in_progress);
endmodule // dsc_top_monitor

bind dsc_top dsc_top_monitor #(.LOW_RES(LOW_RES), .BASE_CYC(BASE_CYC)) dsc_top_monitor_i (
  .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .alarm_in(alarm_in), .break_mode_interface(break_mode_interface), .sdi_in(sdi_in),
  .dac_code(dac_code), .range_narrow(range_narrow), .clear_state(clear_state),
  .slew_in_progress(slew_in_progress));

// *** tb/tb_top.sv ***
// Self-checking bench for the slew and clear control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BASE = 1;
  localparam logic [3:0]  A_DAT = dsc_pkg::OFS_DATA;
  localparam logic [3:0]  A_CLR = dsc_pkg::OFS_CLR_CODE;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [3:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data;
  logic        alarm_in;
  logic        break_mode_interface;
  logic        sdi_in;
  logic [15:0] dac_code;
  logic        range_narrow;
  logic        clear_state;
  logic        slew_in_progress;
  logic [15:0] v;
  int          n_mismatch;
  int          num_checks;
  int          cyc;
  int          n;
  int          f;
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  dsc_top #(.LOW_RES(1'h0), .BASE_CYC(BASE)) dsc_top_i (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .alarm_in(alarm_in), .break_mode_interface(break_mode_interface), .sdi_in(sdi_in),
    .dac_code(dac_code), .range_narrow(range_narrow), .clear_state(clear_state),
    .slew_in_progress(slew_in_progress));
  dsc_host dsc_host_i (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    dsc_host_i.wr(a, d);
  endtask
  task automatic ws(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic cf(input int rng, crng, clr, en, stp, rt, prof);
    wr(dsc_pkg::OFS_CFG, {5'h00, prof[0], rt[2:0], stp[2:0], en[0], clr[0], crng[0], rng[0]});
  endtask
  task automatic direct(input logic [15:0] d);
    cf(0, 0, 0, 0, 0, 0, 0);
    wr(A_DAT, d);
    ws(4);
    chk(dac_code, d);
  endtask
  // Linear mode wants full steps until the remainder; ease in and out only bounded ones
  task automatic watch(input logic [15:0] t, input int stp, input int per, input bit lin);
    logic [15:0] last;
    int gap, dl, rem;
    bit bad;
    last = dac_code;
    n = 0;
    gap = 0;
    bad = 0;
    for (int k = 0; k < 3000 && last !== t; k++) begin
      @(posedge clk);
      #1;
      gap++;
      if (dac_code !== last) begin
        dl = dac_code > last ? dac_code - last : last - dac_code;
        rem = t > last ? t - last : last - t;
        if (lin ? dl != (rem < stp ? rem : stp) : (dl > stp || dl > rem)) bad = 1;
        if ((t > last) != (dac_code > last)) bad = 1;
        if (n > 0 && gap != per) bad = 1;
        if (n == 0) f = dl;
        n++;
        gap = 0;
        last = dac_code;
      end
    end
    chk(bad, 0);
    chk(last, t);
  endtask
  function automatic logic [15:0] cal(input logic [15:0] d, g, o);
    int r;
    r = (longint'(d) * (32768 + g)) >> 16;
    r = r + int'($signed(o));
    return r < 0 ? 16'h0000 : (r > 65535 ? 16'hFFFF : r[15:0]);
  endfunction
  task automatic t_cal;
    logic [15:0] g[6] = '{16'h8000, 16'h0000, 16'hFFFF, 16'h8000, 16'hC000, 16'h8000};
    logic [15:0] o[6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFE, 16'h0005, 16'h8000};
    logic [15:0] d[6] = '{16'h1234, 16'hFFFF, 16'hFFFF, 16'h0010, 16'h4000, 16'h0001};
    chk(dac_code, 16'h0000);
    chk({range_narrow, clear_state, slew_in_progress}, 16'h0000);
    dsc_host_i.rd(dsc_pkg::OFS_CFG, v);
    chk(v, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(dsc_pkg::OFS_GAIN, g[i]);
      wr(dsc_pkg::OFS_OFFSET, o[i]);
      wr(A_DAT, d[i]);
      ws(4);
      chk(dac_code, cal(d[i], g[i], o[i]));
    end
    wr(dsc_pkg::OFS_GAIN, 16'h8000);
    wr(dsc_pkg::OFS_OFFSET, 16'h0000);
  endtask
  task automatic t_slew;
    logic [15:0] t;
    for (int i = 0; i < 8; i++) begin
      t = i[0] ? 16'h1000 - (5 * (1 << i) + 3) : 16'h1000 + (5 * (1 << i) + 3);
      direct(16'h1000);
      cf(i % 2, 0, 0, 1, i, 7 - i, 0);
      wr(A_DAT, t);
      watch(t, 1 << i, BASE << (7 - i), 1);
      chk(n, 16'((5 * (1 << i) + 3 + (1 << i) - 1) >> i));
      chk(range_narrow, i % 2);
    end
    direct(16'h2000);
    cf(0, 0, 0, 1, 5, 0, 1);
    wr(A_DAT, 16'h2400);
    watch(16'h2400, 32, BASE, 0);
    chk(f < 32, 1);
    chk(n > 32, 1);
    direct(16'h1000);
    cf(0, 0, 0, 1, 0, 0, 0);
    wr(A_DAT, 16'h1100);
    ws(20);
    wr(A_DAT, 16'h0F00);
    ws(6);
    v = dac_code;
    watch(16'h0F00, 1, BASE, 1);
    chk(n, v - 16'h0F00);
    direct(16'h1000);
    cf(0, 0, 0, 1, 0, 7, 0);
    wr(A_DAT, 16'h2000);
    ws(300);
    chk(slew_in_progress, 1);
    cf(0, 0, 0, 0, 0, 7, 0);
    ws(1);
    chk(slew_in_progress, 16'h0000);
    chk(dac_code, 16'h2000);
  endtask
  task automatic t_clear;
    direct(16'h1234);
    wr(A_CLR, 16'h0ABC);
    for (int s = 0; s < 5; s++) begin
      wr(dsc_pkg::OFS_ALARM, s == 1);
      cf(0, 1, s == 0, 0, 0, 0, 0);
      @(posedge clk);
      alarm_in <= s == 1 || s == 4;
      sdi_in <= s == 2 || s == 3;
      break_mode_interface <= s == 2;
      ws(6);
      chk({clear_state, range_narrow}, s < 3 ? 16'h0003 : 16'h0000);
      chk(dac_code, s < 3 ? 16'h0ABC : 16'h1234);
      dsc_host_i.rd(dsc_pkg::OFS_STATUS, v);
      chk(v, s < 3 ? 16'h0006 : 16'h0000);
      dsc_host_i.rd(A_DAT, v);
      chk(v, 16'h1234);
      cf(0, 1, 0, 0, 0, 0, 0);
      @(posedge clk);
      alarm_in <= 1'h0;
      sdi_in <= 1'h0;
      break_mode_interface <= 1'h0;
      ws(6);
      chk({clear_state, range_narrow}, 16'h0000);
      chk(dac_code, 16'h1234);
    end
    direct(16'h1000);
    wr(A_CLR, 16'h1040);
    cf(0, 0, 0, 1, 2, 0, 0);
    cf(0, 0, 1, 1, 2, 0, 0);
    watch(16'h1040, 4, BASE, 1);
    chk(n, 16);
    cf(0, 0, 0, 1, 2, 0, 0);
    watch(16'h1000, 4, BASE, 1);
    chk(n, 16);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    alarm_in = 1'h0;
    break_mode_interface = 1'h0;
    sdi_in = 1'h0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    ws(1);
    t_cal();
    t_slew();
    t_clear();
    conclude();
  end
endmodule // tb_top
